// >>> common/nvd_pkg.sv
// constants for the nv defaults and fail-safe select block
package nvd_pkg;
	localparam int NVD_CH = 12;
	localparam int NVD_NV_WORDS = 16;
	localparam int NVD_NV_AW = 4;
	// nv word indices
	localparam logic [3:0] NV_IDX_PWM = 4'h0;
	localparam logic [3:0] NV_IDX_SUPTH = 4'h1;
	localparam logic [3:0] NV_IDX_DIAG_LO = 4'h2;
	localparam logic [3:0] NV_IDX_DIAG_HI = 4'h3;
	localparam logic [3:0] NV_IDX_OD = 4'h4;
	localparam logic [3:0] NV_IDX_SHORT = 4'h5;
	localparam logic [3:0] NV_IDX_WD = 4'h6;
	localparam logic [3:0] NV_IDX_FS0_LO = 4'h7;
	localparam logic [3:0] NV_IDX_FS0_HI = 4'h8;
	localparam logic [3:0] NV_IDX_FS1_LO = 4'h9;
	localparam logic [3:0] NV_IDX_FS1_HI = 4'hA;
	localparam logic [3:0] NV_IDX_MISC = 4'hB;
	localparam logic [3:0] NV_IDX_CRC = 4'hF;
	localparam logic [3:0] NV_IDX_LAST = 4'hF;
	// field positions
	localparam int F_PWM_FREQ_LSB = 0;
	localparam int F_PWM_FREQ_W = 4;
	localparam int F_EXP_EN = 4;
	localparam int F_OD_CUR_LSB = 0;
	localparam int F_OD_CUR_W = 4;
	localparam int F_OD_PW_LSB = 4;
	localparam int F_OD_PW_W = 4;
	localparam int F_SHORT_TH_LSB = 0;
	localparam int F_SHORT_TH_W = 7;
	localparam int F_SHORT_AUTO = 7;
	localparam int F_WD_LSB = 0;
	localparam int F_WD_W = 4;
	localparam int F_OFAF = 0;
	// factory image
	localparam logic [7:0] NV_DEF_PWM = 8'h00;
	localparam logic [7:0] NV_DEF_SUPTH = 8'h00;
	localparam logic [7:0] NV_DEF_DIAG = 8'hFF;
	localparam logic [7:0] NV_DEF_OD = 8'h00;
	localparam logic [7:0] NV_DEF_SHORT = 8'h00;
	localparam logic [7:0] NV_DEF_WD = 8'h00;
	localparam logic [7:0] NV_DEF_FS0 = 8'h00;
	localparam logic [7:0] NV_DEF_FS1 = 8'hFF;
	localparam logic [7:0] NV_DEF_MISC = 8'h00;
	localparam logic [7:0] NV_DEF_OTHER = 8'h00;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	// register byte addresses (word index * 4)
	localparam logic [5:0] A_CTRL = 6'h00;
	localparam logic [5:0] A_STATUS = 6'h04;
	localparam logic [5:0] A_NV_ADDR = 6'h08;
	localparam logic [5:0] A_NV_DATA = 6'h0C;
	localparam logic [5:0] A_PWM = 6'h10;
	localparam logic [5:0] A_SUPTH = 6'h14;
	localparam logic [5:0] A_DIAG = 6'h18;
	localparam logic [5:0] A_OD = 6'h1C;
	localparam logic [5:0] A_SHORT = 6'h20;
	localparam logic [5:0] A_WD = 6'h24;
	localparam logic [5:0] A_DUTY_SEL = 6'h28;
	localparam logic [5:0] A_DUTY = 6'h2C;
	localparam logic [5:0] A_CRC = 6'h30;
	// ctrl bits
	localparam int C_RELOAD = 0;
	localparam int C_SAFE_FORCE = 1;
	localparam int C_WD_KICK = 2;
	// status bits
	localparam int S_LOADED = 0;
	localparam int S_CRC_ERR = 1;
	localparam int S_FAILSAFE = 2;
	localparam int S_SAFE_SEL = 3;
	// watchdog base tick 1 ms at 20 MHz
	localparam int CLK_HZ = 20_000_000;
	localparam int WD_TICK_US = 1000;
	localparam int WD_TICK_CYC = CLK_HZ / 1_000_000 * WD_TICK_US;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
	typedef enum logic [1:0] {NVD_IDLE, NVD_READ, NVD_WAIT, NVD_DONE} nvd_load_t;
endpackage

// >>> core/nvd_mem.sv
// nv store: 16 bytes, registered read, factory image at reset
module nvd_mem
	import nvd_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [NVD_NV_AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [NVD_NV_AW-1:0] rd_addr,
	output logic [7:0] rd_data_ff
);
	logic [7:0] mem_ff [NVD_NV_WORDS];

	function automatic logic [7:0] factory(input int i);
		case (i)
			NV_IDX_DIAG_LO, NV_IDX_DIAG_HI: factory = NV_DEF_DIAG;
			NV_IDX_FS1_LO, NV_IDX_FS1_HI: factory = NV_DEF_FS1;
			default: factory = NV_DEF_OTHER;
		endcase
	endfunction

	genvar g;
	generate
		for (g = 0; g < NVD_NV_WORDS; g++) begin : g_w
			always_ff @(posedge clock or posedge rst) begin
				if (rst)
					mem_ff[g] <= factory(g);
				else if (wr_en && wr_addr == NVD_NV_AW'(g))
					mem_ff[g] <= wr_data;
			end
		end
	endgenerate

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rd_data_ff <= 8'h00;
		else
			rd_data_ff <= mem_ff[rd_addr];
	end
endmodule

// >>> core/nvd_top.sv
// nv defaults loader, fail-safe map select, one-fails-all-fail and crc check
// What this block does
// - after reset or reload each runtime setting takes its default from its nv field.
// - each channel's fault diagnostics pass only when its diagnostic-enable bit is set.
// - in fail-safe each channel output follows its own bit of the active nv map, except while one-fails-all-fail holds all outputs off.
// - the fail-safe select pin low picks map 0 and high picks map 1.
// - factory map 0 is all zero and map 1 all one, so the pin gates all outputs.
// - one-fails-all-fail is active only with its nv bit at 1, on a shared open-drain fault line.
// - the watchdog time setting governs entry into fail-safe and defaults from nv.
// - the exponential-enable setting picks linear or exponential dimming of the duty fields.
module nvd_top
	import nvd_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic failsafe_select_pin,
	input wire logic [NVD_CH-1:0] channel_fault_raw,
	input wire logic [NVD_CH-1:0] channel_on_normal,
	output logic [NVD_CH-1:0] channel_fault_masked,
	output logic [NVD_CH-1:0] channel_on,
	output logic [NVD_CH-1:0] channel_duty_sel,
	output logic [3:0] pwm_frequency_setting,
	output logic exponential_dimming_enable,
	output logic [7:0] low_supply_threshold,
	output logic [3:0] ondemand_diag_current,
	output logic [3:0] ondemand_diag_pulse_width,
	output logic auto_led_short_enable,
	output logic [6:0] led_short_threshold,
	output logic [3:0] watchdog_time_setting,
	output logic failsafe_active,
	output logic config_error,
	input wire logic fault_line_in,
	output logic fault_line_out,
	output logic fault_line_oe
);
	logic [7:0] nv_rd_data;
	logic [3:0] ld_addr_ff, nxt_ld_addr;
	nvd_load_t ld_state_ff, nxt_ld_state;
	logic [7:0] crc_ff, nxt_crc;
	logic loaded_ff;
	logic crc_err_ff;
	logic [3:0] pwm_ff;
	logic exp_ff;
	logic [7:0] supth_ff;
	logic [NVD_CH-1:0] diag_ff;
	logic [3:0] od_cur_ff;
	logic [3:0] od_pw_ff;
	logic [6:0] short_th_ff;
	logic short_auto_ff;
	logic [3:0] wd_ff;
	logic [NVD_CH-1:0] fs0_ff;
	logic [NVD_CH-1:0] fs1_ff;
	logic ofaf_ff;
	logic [3:0] nv_addr_ff;
	logic safe_force_ff;
	logic [3:0] duty_idx_ff;
	logic [11:0] duty_hi_ff [NVD_CH];
	logic [11:0] duty_lo_ff [NVD_CH];
	logic [31:0] rdata_ff;
	logic rvalid_ff;
	logic [2:0] safe_sync_ff;
	logic safe_level_ff;
	logic [2:0] fl_sync_ff;
	logic fl_level_ff;
	logic [14:0] tick_ff;
	logic [3:0] wd_cnt_ff;
	logic wd_expired_ff;

	// bus decode
	wire wr = avs_write;
	wire rd = avs_read;
	wire wr_ctrl = wr && avs_address == A_CTRL;
	wire wr_nv_data = wr && avs_address == A_NV_DATA;
	wire reload = (wr_ctrl && avs_writedata[C_RELOAD]) || (ld_state_ff == NVD_IDLE && !loaded_ff);
	wire wd_kick = wr && avs_address != A_STATUS;
	wire loading = ld_state_ff != NVD_IDLE;
	wire ld_take = ld_state_ff == NVD_WAIT;
	wire [NVD_NV_AW-1:0] mem_rd_addr = loading ? ld_addr_ff : nv_addr_ff;
	wire [7:0] duty_sel_idx = {4'h0, duty_idx_ff};

	nvd_mem u_mem (
		.clock(clock),
		.rst(rst),
		.wr_en(wr_nv_data && !loading),
		.wr_addr(nv_addr_ff),
		.wr_data(avs_writedata[7:0]),
		.rd_addr(mem_rd_addr),
		.rd_data_ff(nv_rd_data)
	);

	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++)
			r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		return r;
	endfunction

	// loader sequence: one nv byte every two cycles
	always_comb begin
		nxt_ld_state = ld_state_ff;
		nxt_ld_addr = ld_addr_ff;
		nxt_crc = crc_ff;
		unique case (ld_state_ff)
			NVD_IDLE: begin
				if (reload) begin
					nxt_ld_state = NVD_READ;
					nxt_ld_addr = 4'h0;
					nxt_crc = CRC_INIT;
				end
			end
			NVD_READ: nxt_ld_state = NVD_WAIT;
			NVD_WAIT: begin
				if (ld_addr_ff != NV_IDX_CRC)
					nxt_crc = crc8_step(crc_ff, nv_rd_data);
				if (ld_addr_ff == NV_IDX_LAST)
					nxt_ld_state = NVD_DONE;
				else begin
					nxt_ld_addr = ld_addr_ff + 4'h1;
					nxt_ld_state = NVD_READ;
				end
			end
			NVD_DONE: nxt_ld_state = NVD_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ld_state_ff <= NVD_IDLE;
			ld_addr_ff <= 4'h0;
			crc_ff <= CRC_INIT;
		end else begin
			ld_state_ff <= nxt_ld_state;
			ld_addr_ff <= nxt_ld_addr;
			crc_ff <= nxt_crc;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			loaded_ff <= 1'b0;
			crc_err_ff <= 1'b0;
		end else if (ld_state_ff == NVD_DONE) begin
			loaded_ff <= 1'b1;
		end else if (ld_take && ld_addr_ff == NV_IDX_CRC) begin
			crc_err_ff <= crc_ff != nv_rd_data;
		end
	end

	// runtime settings: nv defaults on load, software writes after
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pwm_ff <= NV_DEF_PWM[F_PWM_FREQ_LSB +: F_PWM_FREQ_W];
			exp_ff <= NV_DEF_PWM[F_EXP_EN];
			supth_ff <= NV_DEF_SUPTH;
			diag_ff <= {NV_DEF_DIAG[3:0], NV_DEF_DIAG};
			od_cur_ff <= NV_DEF_OD[F_OD_CUR_LSB +: F_OD_CUR_W];
			od_pw_ff <= NV_DEF_OD[F_OD_PW_LSB +: F_OD_PW_W];
			short_th_ff <= NV_DEF_SHORT[F_SHORT_TH_LSB +: F_SHORT_TH_W];
			short_auto_ff <= NV_DEF_SHORT[F_SHORT_AUTO];
			wd_ff <= NV_DEF_WD[F_WD_LSB +: F_WD_W];
			fs0_ff <= {NV_DEF_FS0[3:0], NV_DEF_FS0};
			fs1_ff <= {NV_DEF_FS1[3:0], NV_DEF_FS1};
			ofaf_ff <= NV_DEF_MISC[F_OFAF];
		end else if (ld_take) begin
			unique case (ld_addr_ff)
				NV_IDX_PWM: begin
					pwm_ff <= nv_rd_data[F_PWM_FREQ_LSB +: F_PWM_FREQ_W];
					exp_ff <= nv_rd_data[F_EXP_EN];
				end
				NV_IDX_SUPTH: supth_ff <= nv_rd_data;
				NV_IDX_DIAG_LO: diag_ff[7:0] <= nv_rd_data;
				NV_IDX_DIAG_HI: diag_ff[11:8] <= nv_rd_data[3:0];
				NV_IDX_OD: begin
					od_cur_ff <= nv_rd_data[F_OD_CUR_LSB +: F_OD_CUR_W];
					od_pw_ff <= nv_rd_data[F_OD_PW_LSB +: F_OD_PW_W];
				end
				NV_IDX_SHORT: begin
					short_th_ff <= nv_rd_data[F_SHORT_TH_LSB +: F_SHORT_TH_W];
					short_auto_ff <= nv_rd_data[F_SHORT_AUTO];
				end
				NV_IDX_WD: wd_ff <= nv_rd_data[F_WD_LSB +: F_WD_W];
				NV_IDX_FS0_LO: fs0_ff[7:0] <= nv_rd_data;
				NV_IDX_FS0_HI: fs0_ff[11:8] <= nv_rd_data[3:0];
				NV_IDX_FS1_LO: fs1_ff[7:0] <= nv_rd_data;
				NV_IDX_FS1_HI: fs1_ff[11:8] <= nv_rd_data[3:0];
				NV_IDX_MISC: ofaf_ff <= nv_rd_data[F_OFAF];
				default: ;
			endcase
		end else if (wr) begin
			unique case (avs_address)
				A_PWM: begin
					pwm_ff <= avs_writedata[F_PWM_FREQ_LSB +: F_PWM_FREQ_W];
					exp_ff <= avs_writedata[F_EXP_EN];
				end
				A_SUPTH: supth_ff <= avs_writedata[7:0];
				A_DIAG: diag_ff <= avs_writedata[NVD_CH-1:0];
				A_OD: begin
					od_cur_ff <= avs_writedata[F_OD_CUR_LSB +: F_OD_CUR_W];
					od_pw_ff <= avs_writedata[F_OD_PW_LSB +: F_OD_PW_W];
				end
				A_SHORT: begin
					short_th_ff <= avs_writedata[F_SHORT_TH_LSB +: F_SHORT_TH_W];
					short_auto_ff <= avs_writedata[F_SHORT_AUTO];
				end
				A_WD: wd_ff <= avs_writedata[F_WD_LSB +: F_WD_W];
				default: ;
			endcase
		end
	end

	// misc software registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			nv_addr_ff <= 4'h0;
			safe_force_ff <= 1'b0;
			duty_idx_ff <= 4'h0;
		end else if (wr) begin
			if (avs_address == A_NV_ADDR)
				nv_addr_ff <= avs_writedata[3:0];
			if (wr_ctrl)
				safe_force_ff <= avs_writedata[C_SAFE_FORCE];
			if (avs_address == A_DUTY_SEL)
				duty_idx_ff <= avs_writedata[3:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < NVD_CH; g++) begin : g_duty
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					duty_hi_ff[g] <= 12'h000;
					duty_lo_ff[g] <= 12'h000;
				end else if (wr && avs_address == A_DUTY && duty_idx_ff == 4'(g)) begin
					duty_hi_ff[g] <= avs_writedata[27:16];
					duty_lo_ff[g] <= avs_writedata[11:0];
				end
			end
		end
	endgenerate

	// watchdog: 1 ms ticks, expiry after setting ticks without a write to any address but STATUS; 0 disables
	wire wd_fire = tick_ff == 15'(WD_TICK_CYC - 1) && wd_ff != 4'h0 && !wd_expired_ff && (wd_cnt_ff + 4'h1) == wd_ff;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_ff <= 15'h0000;
			wd_cnt_ff <= 4'h0;
			wd_expired_ff <= 1'b0;
		end else if (wd_kick) begin
			tick_ff <= 15'h0000;
			wd_cnt_ff <= 4'h0;
			wd_expired_ff <= wd_fire;
		end else if (tick_ff == 15'(WD_TICK_CYC - 1)) begin
			tick_ff <= 15'h0000;
			if (wd_ff != 4'h0 && !wd_expired_ff) begin
				wd_cnt_ff <= wd_cnt_ff + 4'h1;
				wd_expired_ff <= (wd_cnt_ff + 4'h1) == wd_ff;
			end
		end else begin
			tick_ff <= tick_ff + 15'h0001;
		end
	end

	// pin synchronisers, change accepted when stages two and three agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			safe_sync_ff <= 3'h0;
			safe_level_ff <= 1'b0;
			fl_sync_ff <= 3'h7;
			fl_level_ff <= 1'b1;
		end else begin
			safe_sync_ff <= {safe_sync_ff[1:0], failsafe_select_pin};
			fl_sync_ff <= {fl_sync_ff[1:0], fault_line_in};
			if (safe_sync_ff[1] == safe_sync_ff[2])
				safe_level_ff <= safe_sync_ff[2];
			if (fl_sync_ff[1] == fl_sync_ff[2])
				fl_level_ff <= fl_sync_ff[2];
		end
	end

	// outputs
	wire safe_on = wd_expired_ff || safe_force_ff;
	wire [NVD_CH-1:0] safe_map = safe_level_ff ? fs1_ff : fs0_ff;
	wire own_fault = |(channel_fault_raw & diag_ff);
	wire ext_fault = ofaf_ff && !fl_level_ff && !own_fault;
	wire [NVD_CH-1:0] map_on = safe_on ? safe_map : channel_on_normal;

	assign channel_fault_masked = channel_fault_raw & diag_ff;
	assign channel_on = ext_fault ? {NVD_CH{1'b0}} : map_on;
	assign fault_line_out = 1'b0;
	assign fault_line_oe = own_fault || crc_err_ff;
	assign failsafe_active = safe_on;
	assign config_error = crc_err_ff;
	assign pwm_frequency_setting = pwm_ff;
	assign exponential_dimming_enable = exp_ff;
	assign low_supply_threshold = supth_ff;
	assign ondemand_diag_current = od_cur_ff;
	assign ondemand_diag_pulse_width = od_pw_ff;
	assign auto_led_short_enable = short_auto_ff;
	assign led_short_threshold = short_th_ff;
	assign watchdog_time_setting = wd_ff;

	// duty select: per-channel high/low fields picked by dimming method
	generate
		for (g = 0; g < NVD_CH; g++) begin : g_dsel
			assign channel_duty_sel[g] = exp_ff ? (duty_hi_ff[g] > duty_lo_ff[g]) : (duty_hi_ff[g] != 12'h000);
		end
	endgenerate

	// read mux, registered, one wait cycle
	wire [31:0] status_word = {28'h0, safe_level_ff, safe_on, crc_err_ff, loaded_ff};
	wire [31:0] duty_word = {4'h0, duty_hi_ff[duty_idx_ff], 4'h0, duty_lo_ff[duty_idx_ff]};
	wire [31:0] rd_mux =
		avs_address == A_CTRL ? {30'h0, safe_force_ff, 1'b0} :
		avs_address == A_STATUS ? status_word :
		avs_address == A_NV_ADDR ? {28'h0, nv_addr_ff} :
		avs_address == A_NV_DATA ? {24'h0, nv_rd_data} :
		avs_address == A_PWM ? {27'h0, exp_ff, pwm_ff} :
		avs_address == A_SUPTH ? {24'h0, supth_ff} :
		avs_address == A_DIAG ? {20'h0, diag_ff} :
		avs_address == A_OD ? {24'h0, od_pw_ff, od_cur_ff} :
		avs_address == A_SHORT ? {24'h0, short_auto_ff, short_th_ff} :
		avs_address == A_WD ? {28'h0, wd_ff} :
		avs_address == A_DUTY_SEL ? {24'h0, duty_sel_idx} :
		avs_address == A_DUTY ? duty_word :
		avs_address == A_CRC ? {24'h0, crc_ff} : RD_UNMAPPED;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_ff <= 32'h0000_0000;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= rd && !rvalid_ff;
			if (rd && !rvalid_ff)
				rdata_ff <= rd_mux;
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = rd && !rvalid_ff;
endmodule

// >>> verification/nvd_fault_peer.sv
// other drivers sharing the open-drain fault line, with its pull-up
module nvd_fault_peer (
	input wire logic clock,
	input wire logic fault_line_oe,
	input wire logic peer_fault,
	output logic fault_line_level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic peer_pull_ff;
	always_ff @(posedge clock) begin
		peer_pull_ff <= peer_fault;
	end
	// wired low by anyone, pulled high otherwise
	assign fault_line_level = !(fault_line_oe || peer_pull_ff);
endmodule

// >>> verification/nvd_top_sva.sv
// assertions on the nvd_top ports
module nvd_top_sva
	import nvd_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [NVD_CH-1:0] channel_fault_raw,
	input wire logic [NVD_CH-1:0] channel_fault_masked,
	input wire logic [NVD_CH-1:0] channel_on_normal,
	input wire logic [NVD_CH-1:0] channel_on,
	input wire logic [3:0] watchdog_time_setting,
	input wire logic failsafe_active,
	input wire logic config_error,
	input wire logic fault_line_out,
	input wire logic fault_line_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	AST_WRITE_NOWAIT: assert property (avs_write |-> !avs_waitrequest)
		else $error("write was stalled");
	AST_READ_ONE_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read wait not one cycle");
	AST_RDATA_HOLD: assert property (!$past(avs_read) |-> $stable(avs_readdata))
		else $error("read data moved without read");
	AST_MASK_SUBSET: assert property ((channel_fault_masked & ~channel_fault_raw) == '0)
		else $error("masked fault without raw fault");
	AST_NORMAL_GATE: assert property (!failsafe_active |-> (channel_on & ~channel_on_normal) == '0)
		else $error("channel on outside fail-safe");
	AST_OE_ON_FAULT: assert property ((|channel_fault_masked || config_error) |-> ##[0:2] fault_line_oe)
		else $error("fault line not pulled");
	AST_OUT_LOW: assert property (fault_line_out == 1'b0)
		else $error("fault line driven high");
	AST_WD_OFF: assert property ((watchdog_time_setting == 4'h0 && !avs_write && !failsafe_active)
		|=> !failsafe_active)
		else $error("fail-safe with watchdog off");
endmodule

bind nvd_top nvd_top_sva u_nvd_top_sva (.clock, .rst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
	.channel_fault_raw, .channel_fault_masked, .channel_on_normal, .channel_on, .watchdog_time_setting,
	.failsafe_active, .config_error, .fault_line_out, .fault_line_oe);

// >>> verification/nvd_top_test.sv
// self-checking bench for nvd_top
module nvd_top_test
	import nvd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, avs_read = 0, avs_write = 0, failsafe_select_pin = 0, peer_fault = 0;
	logic [5:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, q, v32, seed = 32'h2724;
	logic avs_waitrequest, exponential_dimming_enable, auto_led_short_enable, failsafe_active, config_error;
	logic fault_line_out, fault_line_oe, fault_line_in;
	logic [NVD_CH-1:0] channel_fault_raw = '0, channel_on_normal = '0, channel_fault_masked, channel_on;
	logic [NVD_CH-1:0] channel_duty_sel;
	logic [3:0] pwm_frequency_setting, ondemand_diag_current, ondemand_diag_pulse_width, watchdog_time_setting;
	logic [7:0] low_supply_threshold;
	logic [6:0] led_short_threshold;
	logic [7:0] img [16];
	int n_mismatch = 0, checks_done = 0;
	always #25 clock = ~clock;
	nvd_top u_nvd_top (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .failsafe_select_pin, .channel_fault_raw, .channel_on_normal, .channel_fault_masked,
		.channel_on, .channel_duty_sel, .pwm_frequency_setting, .exponential_dimming_enable, .low_supply_threshold,
		.ondemand_diag_current, .ondemand_diag_pulse_width, .auto_led_short_enable, .led_short_threshold,
		.watchdog_time_setting, .failsafe_active, .config_error, .fault_line_in, .fault_line_out, .fault_line_oe);
	nvd_fault_peer u_nvd_fault_peer (.clock, .fault_line_oe, .peer_fault, .fault_line_level(fault_line_in));
	function logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function logic [7:0] crc8();
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 0; i < 15; i++) begin
			c = c ^ img[i];
			for (int b = 0; b < 8; b++)
				c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	task conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic [5:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			n_mismatch++;
			conclude();
		end
	endtask
	task wait_loaded();
		int n;
		n = 0;
		repeat (36) @(posedge clock);
		do begin
			bus(A_STATUS, 0, 0);
			n++;
		end while (q[S_LOADED] !== 1'b1 && n < 20);
		chk("loaded", 1, q[S_LOADED]);
	endtask
	task nvw(input logic [3:0] i, input logic [7:0] v);
		bus(A_NV_ADDR, 1, {28'h0, i});
		bus(A_NV_DATA, 1, {24'h0, v});
		img[i] = v;
	endtask
	task reload();
		bus(A_CTRL, 1, 32'h1);
		wait_loaded();
	endtask
	task commit();
		nvw(NV_IDX_CRC, crc8());
		reload();
	endtask
	task sel_pin(input logic p, input logic [11:0] e);
		failsafe_select_pin <= p;
		repeat (6) @(posedge clock);
		chk("channel_on", e, channel_on);
	endtask
	initial begin
		int n;
		for (int i = 0; i < 16; i++)
			img[i] = (i == 2 || i == 3 || i == 9 || i == 10) ? 8'hFF : 8'h00;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		wait_loaded();
		chk("pwm", 0, pwm_frequency_setting);
		chk("wd", 0, watchdog_time_setting);
		chk("crc_err", crc8() != img[15], config_error);
		bus(A_DIAG, 0, 0);
		chk("diag", 32'hFFF, q);
		bus(6'h3C, 1, 32'hFFFF_FFFF);
		bus(6'h3C, 0, 0);
		chk("unmapped", RD_UNMAPPED, q);
		bus(A_CTRL, 1, 32'h2);
		sel_pin(0, 12'h000);
		sel_pin(1, 12'hFFF);
		bus(A_CTRL, 1, 0);
		$display("test factory done");
		repeat (4) begin
			v32 = rnd();
			bus(A_DIAG, 1, v32);
			channel_fault_raw <= v32[27:16];
			repeat (2) @(posedge clock);
			chk("masked", v32[27:16] & v32[11:0], channel_fault_masked);
			chk("fault_oe", |(v32[27:16] & v32[11:0]) || crc8() != img[15], fault_line_oe);
		end
		channel_fault_raw <= '0;
		$display("test masking done");
		for (int i = 0; i < 11; i++) begin
			v32 = rnd();
			nvw(i[3:0], i == 6 ? {4'h0, v32[3:0] | 4'h1} : v32[7:0]);
		end
		commit();
		chk("pwm", img[0][3:0], pwm_frequency_setting);
		chk("exp", img[0][4], exponential_dimming_enable);
		chk("supth", img[1], low_supply_threshold);
		chk("od_cur", img[4][3:0], ondemand_diag_current);
		chk("od_pw", img[4][7:4], ondemand_diag_pulse_width);
		chk("short_th", img[5][6:0], led_short_threshold);
		chk("short_auto", img[5][7], auto_led_short_enable);
		chk("wd", img[6][3:0], watchdog_time_setting);
		chk("crc_err", 0, config_error);
		bus(A_DIAG, 0, 0);
		chk("diag", {img[3][3:0], img[2]}, q[11:0]);
		bus(A_CTRL, 1, 32'h2);
		sel_pin(0, {img[8][3:0], img[7]});
		sel_pin(1, {img[10][3:0], img[9]});
		bus(A_CTRL, 1, 0);
		nvw(NV_IDX_CRC, img[15] ^ 8'h01);
		reload();
		chk("crc_err", 1, config_error);
		$display("test defaults done");
		for (int o = 0; o < 2; o++) begin
			nvw(NV_IDX_MISC, {7'h0, o[0]});
			commit();
			v32 = rnd();
			channel_on_normal <= v32[11:0];
			peer_fault <= 1'b1;
			repeat (6) @(posedge clock);
			chk("channel_on", o ? 12'h000 : v32[11:0], channel_on);
			peer_fault <= 1'b0;
		end
		$display("test shared fault done");
		for (int e = 0; e < 2; e++) begin
			bus(A_PWM, 1, {27'h0, e[0], 4'h0});
			bus(A_DUTY_SEL, 1, 32'd11);
			bus(A_DUTY, 1, {4'h0, 12'h005, 4'h0, 12'h009});
			@(posedge clock);
			chk("duty_sel", e ? 0 : 1, channel_duty_sel[11]);
		end
		$display("test dimming done");
		bus(A_WD, 1, 32'h2);
		repeat (2 * WD_TICK_CYC - 10) @(posedge clock);
		chk("failsafe", 0, failsafe_active);
		n = 0;
		while (failsafe_active !== 1'b1 && n < 30) begin
			@(posedge clock);
			n++;
		end
		chk("failsafe", 1, failsafe_active);
		chk("wd_cycles", 11, n);
		$display("test watchdog done");
		conclude();
	end
endmodule
